// ===== bench/sci_remote_node.sv
// Far-side serial node: frame catcher on the transmit line, frame sender on the receive line
module sci_remote_node (
	input wire logic core_clk,
	input wire logic line_in,
	input wire logic nine,
	input wire logic send,
	input wire logic [8:0] send_data,
	output logic rx_line,
	output logic got,
	output logic [9:0] got_bits
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT_CLKS = 16;
	logic [10:0] frame;
	initial begin
		got = 1'b0;
		got_bits = '0;
		forever begin
			@(posedge core_clk);
			if (!line_in) begin
				repeat (BIT_CLKS / 2) @(posedge core_clk);
				got_bits = '0;
				// Bits land LSB first, stop bit last
				for (int i = 0; i < (nine ? 10 : 9); i++) begin
					repeat (BIT_CLKS) @(posedge core_clk);
					got_bits[i] = line_in;
				end
				got <= 1'b1;
				@(posedge core_clk);
				got <= 1'b0;
				// A held low line is one long break, not a run of new starts
				while (!line_in) @(posedge core_clk);
			end
		end
	end
	initial begin
		rx_line = 1'b1;
		forever begin
			@(posedge core_clk);
			if (send) begin
				frame = nine ? {1'b1, send_data, 1'b0} : {2'b11, send_data[7:0], 1'b0};
				for (int i = 0; i < (nine ? 11 : 10); i++) begin
					rx_line <= frame[i];
					repeat (BIT_CLKS) @(posedge core_clk);
				end
				rx_line <= 1'b1;
			end
		end
	end
endmodule

// ===== bench/test_sci_control_registers.sv
// Self-checking bench for the serial control registers
module test_sci_control_registers
	import sci_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [2:0] addr = '0;
	logic [7:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_q = 1'b0;
	logic [7:0] rdata;
	logic rxd_pin, txd_out, txd_oe, tx_irq, rx_irq, got;
	logic nine = 1'b0;
	logic send = 1'b0;
	logic [8:0] send_data = '0;
	logic [9:0] got_bits, fexp;
	logic [9:0] fq[$];
	logic [7:0] rq[$];
	logic [7:0] mq[$];
	string nq[$];
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int n;
	logic [7:0] d, cfg;
	logic odd, t8;
	// Tri-state pin with a pull-up: released means high
	wire logic txd_line = txd_oe ? txd_out : 1'b1;

	sci_control_registers u_dut (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .rxd_pin(rxd_pin), .txd_out(txd_out),
		.txd_oe(txd_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
	sci_remote_node u_far (.core_clk(core_clk), .line_in(txd_line), .nine(nine), .send(send),
		.send_data(send_data), .rx_line(rxd_pin), .got(got), .got_bits(got_bits));

	initial forever #10 core_clk = ~core_clk;

	task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
		@(posedge core_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
		@(negedge core_clk);
	endtask
	task automatic rd_reg(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m,
		input string w);
		@(posedge core_clk);
		rq.push_back(e & m);
		mq.push_back(m);
		nq.push_back(w);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
	endtask
	task automatic remote_send(input logic [8:0] v);
		@(posedge core_clk);
		send_data <= v;
		send <= 1'b1;
		@(posedge core_clk);
		send <= 1'b0;
		repeat (12 * 16) @(posedge core_clk);
	endtask
	task automatic drain;
		for (int i = 0; i < 3000 && fq.size() > 0; i++) @(posedge core_clk);
		chk("frames pending", 10'(fq.size()), '0);
	endtask
	task automatic wait_irq(input logic rx);
		for (int i = 0; i < 1500 && (rx ? rx_irq : tx_irq) !== 1'b1; i++) @(posedge core_clk);
		chk("irq wait", rx ? rx_irq : tx_irq, 1'b1);
	endtask
	function automatic logic [9:0] frame_of(input logic [7:0] v, input logic t9,
		input logic p, input logic o, input logic nb);
		if (nb) return {1'b1, p ? ^v ^ o : t9, v};
		return {2'b01, p ? ^v[6:0] ^ o : v[7], v[6:0]};
	endfunction

	always @(posedge core_clk) rd_q <= rd;
	// Read data stands only in the cycle after the strobe, so look mid-cycle
	always @(negedge core_clk) begin
		if (rd_q) chk(nq.pop_front(), {2'b00, rdata & mq.pop_front()}, {2'b00, rq.pop_front()});
	end
	always @(posedge core_clk) begin
		if (got) begin
			fexp = fq.size() ? fq.pop_front() : 'x;
			chk("frame", got_bits, fexp);
		end
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_errors++;
			results;
		end
	end

	initial begin
		cfg = 8'($urandom(32'h63bd1cd8));
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		@(negedge core_clk);
		chk("txd_oe", txd_oe, 1'b0);
		chk("txd_out", txd_out, 1'b1);
		chk("tx_irq", tx_irq, 1'b0);
		rd_reg(ADDR_CTRL_ONE, 8'h00, 8'hff, "ctrl_one");
		rd_reg(ADDR_CTRL_TWO, 8'h00, 8'hff, "ctrl_two");
		rd_reg(ADDR_STATUS, 8'hc0, 8'hff, "status");
		rd_reg(3'h6, 8'h00, 8'hff, "unmapped");
		repeat (4) begin
			cfg = 8'($urandom());
			wr_reg(ADDR_CTRL_ONE, cfg);
			rd_reg(ADDR_CTRL_ONE, cfg & CTRL_ONE_MASK, 8'hff, "ctrl_one rw");
		end
		$display("test reset and access done");
		wr_reg(ADDR_CTRL_ONE, 8'h40);
		wr_reg(ADDR_CTRL_TWO, 8'h80);
		chk("tx_irq empty", tx_irq, 1'b1);
		wr_reg(ADDR_CTRL_TWO, 8'h40);
		chk("tx_irq done", tx_irq, 1'b1);
		wr_reg(ADDR_CTRL_ONE, 8'h00);
		chk("tx_irq off", tx_irq, 1'b0);
		rd_reg(ADDR_STATUS, 8'hc0, 8'hc0, "status off");
		wr_reg(ADDR_CTRL_ONE, 8'h40);
		wr_reg(ADDR_CTRL_TWO, 8'h00);
		$display("test interrupts done");
		for (int f = 0; f < 4; f++) begin
			odd = 1'($urandom());
			t8 = 1'($urandom());
			nine <= f[1];
			cfg = {3'b010, f[1], 2'b00, f[0], odd};
			wr_reg(ADDR_CTRL_ONE, cfg);
			wr_reg(ADDR_CTRL_THREE, {1'b0, t8, 6'h00});
			wr_reg(ADDR_CTRL_TWO, 8'h88);
			chk("txd_oe on", txd_oe, 1'b1);
			repeat (2) begin
				d = 8'($urandom());
				fq.push_back(frame_of(d, t8, f[0], odd, f[1]));
				wr_reg(ADDR_DATA, d);
				wait_irq(1'b0);
			end
			// Second character is already in the shifter when the enable drops
			wr_reg(ADDR_CTRL_TWO, 8'h00);
			drain;
			repeat (16) @(posedge core_clk);
			chk("txd_oe idle", txd_oe, 1'b0);
			rd_reg(ADDR_STATUS, 8'hc0, 8'hc0, "status idle");
		end
		$display("test frame formats done");
		nine <= 1'b0;
		wr_reg(ADDR_CTRL_ONE, 8'h40);
		// The break replaces the preamble and is caught long before the gap count ends
		fq.push_back(10'h000);
		wr_reg(ADDR_CTRL_TWO, 8'h09);
		repeat (200) @(posedge core_clk);
		n = 0;
		repeat (320) begin
			@(posedge core_clk);
			n += txd_line;
		end
		chk("break gap", 10'(n), '0);
		wr_reg(ADDR_CTRL_TWO, 8'h08);
		fq.push_back(frame_of(8'ha5, 1'b0, 1'b0, 1'b0, 1'b0));
		wr_reg(ADDR_DATA, 8'ha5);
		drain;
		wr_reg(ADDR_CTRL_TWO, 8'h00);
		$display("test break done");
		nine <= 1'b1;
		wr_reg(ADDR_CTRL_ONE, 8'hd0);
		wr_reg(ADDR_CTRL_THREE, 8'h40);
		wr_reg(ADDR_CTRL_TWO, 8'h2c);
		d = 8'($urandom());
		fq.push_back(frame_of(d, 1'b1, 1'b0, 1'b0, 1'b1));
		wr_reg(ADDR_DATA, d);
		wait_irq(1'b1);
		rd_reg(ADDR_DATA, d, 8'hff, "echo data");
		rd_reg(ADDR_CTRL_THREE, 8'hc0, 8'hff, "ninth bits");
		fq.push_back(frame_of(~d, 1'b1, 1'b0, 1'b0, 1'b1));
		wr_reg(ADDR_DATA, ~d);
		wait_irq(1'b1);
		wr_reg(ADDR_CTRL_TWO, 8'h08);
		rd_reg(ADDR_STATUS, 8'h20, 8'h20, "rx flag kept");
		drain;
		rd_reg(ADDR_DATA, ~d, 8'hff, "echo data two");
		wr_reg(ADDR_CTRL_TWO, 8'h00);
		$display("test loop-back done");
		nine <= 1'b0;
		for (int b = 0; b < 2; b++) begin
			odd = 1'($urandom());
			d = 8'($urandom());
			d[7] = ^d[6:0] ^ odd ^ b[0];
			wr_reg(ADDR_CTRL_ONE, {6'b010000, 1'b1, odd});
			wr_reg(ADDR_CTRL_TWO, 8'h04);
			remote_send({1'b0, d});
			rd_reg(ADDR_STATUS, {2'b00, 1'b1, 4'h0, b[0]}, 8'h21, "parity flag");
			rd_reg(ADDR_CTRL_THREE, {d[7], 7'h00}, 8'h80, "rx ninth");
			rd_reg(ADDR_DATA, d, 8'h7f, "rx data");
		end
		$display("test receive parity done");
		wr_reg(ADDR_CTRL_ONE, 8'h48);
		wr_reg(ADDR_CTRL_TWO, 8'h06);
		remote_send(9'h081);
		rd_reg(ADDR_CTRL_TWO, 8'h00, 8'h02, "standby woken");
		// Receiver off first so the idle count starts from zero
		wr_reg(ADDR_CTRL_TWO, 8'h00);
		wr_reg(ADDR_CTRL_ONE, 8'h44);
		wr_reg(ADDR_CTRL_TWO, 8'h06);
		rd_reg(ADDR_CTRL_TWO, 8'h06, 8'h06, "standby set");
		repeat (200) @(posedge core_clk);
		rd_reg(ADDR_CTRL_TWO, 8'h04, 8'h06, "idle woken");
		repeat (2) @(posedge core_clk);
		$display("test standby done");
		results;
	end
endmodule

// ===== design/sci_control_registers.sv
// Serial unit control registers with transmit and receive paths
module sci_control_registers
	import sci_ctrl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic rxd_pin,
	output logic txd_out,
	output logic txd_oe,
	output logic tx_irq,
	output logic rx_irq
);
	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_START = 3'b010,
		RX_DATA = 3'b100
	} rx_state_e;

	logic [7:0] ctrl_one_r;
	logic [7:0] ctrl_two_r;
	logic [7:0] baud_r;
	logic [7:0] tx_data_r;
	logic [7:0] rx_data_r;
	logic tx_ninth_r;
	logic rx_ninth_r;
	logic tx_empty_r;
	logic rx_full_r;
	logic quiet_r;
	logic par_bad_r;
	logic quiet_armed_r;
	logic [12:0] tx_div_r;
	logic rx_sync1_r;
	logic rx_sync2_r;
	rx_state_e rx_state_r;
	logic [12:0] rx_cnt_r;
	logic [3:0] rx_bits_r;
	logic [9:0] rx_sh_r;
	logic [3:0] quiet_cnt_r;

	logic internal_echo_sel;
	logic serial_unit_on;
	logic char_length_sel;
	logic rx_rouse_sel;
	logic quiet_count_start_sel;
	logic parity_on;
	logic parity_odd_sel;
	logic tx_on;
	logic rx_on;
	logic rx_standby;
	logic break_send;
	logic [12:0] period;
	logic [3:0] frame_len;
	logic tx_tick;
	logic tx_take;
	logic tx_busy;
	logic tx_queued;
	logic txd_line;
	logic tx_empty_flag;
	logic tx_done_flag;
	logic rx_en;
	logic rx_in;
	logic rx_sample;
	logic rx_done;
	logic [9:0] rx_full_frame;
	logic [7:0] rx_char;
	logic rx_msb;
	logic rx_par_fail;
	logic rx_accept;
	logic quiet_inc;
	logic quiet_hit;
	logic wake;
	logic data_rd;
	logic data_wr;

	function automatic logic [12:0] bit_period(input logic [7:0] div);
		bit_period = ({5'h00, div} + 13'h0001) << OVERSAMPLE_SHIFT;
	endfunction

	assign internal_echo_sel = ctrl_one_r[C1_ECHO];
	assign serial_unit_on = ctrl_one_r[C1_UNIT];
	assign char_length_sel = ctrl_one_r[C1_LEN];
	assign rx_rouse_sel = ctrl_one_r[C1_ROUSE];
	assign quiet_count_start_sel = ctrl_one_r[C1_QSTART];
	assign parity_on = ctrl_one_r[C1_PAR];
	assign parity_odd_sel = ctrl_one_r[C1_ODD];
	assign tx_on = ctrl_two_r[C2_TX_ON];
	assign rx_on = ctrl_two_r[C2_RX_ON];
	assign rx_standby = ctrl_two_r[C2_STBY];
	assign break_send = ctrl_two_r[C2_BRK];
	assign period = bit_period(baud_r);
	assign frame_len = char_length_sel ? FRAME_LONG : FRAME_SHORT;
	assign data_rd = rd && addr == ADDR_DATA;
	assign data_wr = wr && addr == ADDR_DATA;

	// Control registers; reserved bits never store so they read zero
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_one_r <= CTRL_RST;
		end else if (wr && addr == ADDR_CTRL_ONE) begin
			ctrl_one_r <= wdata & CTRL_ONE_MASK;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_two_r <= CTRL_RST;
		end else begin
			if (wr && addr == ADDR_CTRL_TWO) begin
				ctrl_two_r <= wdata;
			end
			if (wake) begin
				ctrl_two_r[C2_STBY] <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			baud_r <= BAUD_RST;
		end else if (wr && addr == ADDR_BAUD) begin
			baud_r <= wdata;
		end
	end

	// No reset here: the ninth bits hold whatever they had
	always_ff @(posedge core_clk) begin
		if (wr && addr == ADDR_CTRL_THREE) begin
			tx_ninth_r <= wdata[C3_TX9];
		end
		if (rx_accept) begin
			rx_ninth_r <= rx_full_frame[8];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tx_data_r <= 8'h00;
		end else if (data_wr) begin
			tx_data_r <= wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_data_r <= 8'h00;
		end else if (rx_accept) begin
			rx_data_r <= rx_char;
		end
	end

	// Transmit bit clock
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tx_div_r <= 13'h0000;
		end else if (!serial_unit_on || tx_div_r >= period - 13'h0001) begin
			tx_div_r <= 13'h0000;
		end else begin
			tx_div_r <= tx_div_r + 13'h0001;
		end
	end
	assign tx_tick = serial_unit_on && tx_div_r >= period - 13'h0001;

	sci_tx_engine u_tx (
		.core_clk(core_clk),
		.rstn(rstn),
		.bit_tick(tx_tick),
		.unit_on(serial_unit_on),
		.tx_on(tx_on),
		.break_send(break_send),
		.nine_bits(char_length_sel),
		.parity_on(parity_on),
		.parity_odd(parity_odd_sel),
		.data_ready(!tx_empty_r),
		.data(tx_data_r),
		.ninth(tx_ninth_r),
		.txd(txd_line),
		.take(tx_take),
		.busy(tx_busy),
		.queued(tx_queued)
	);

	assign txd_out = txd_line;
	assign txd_oe = serial_unit_on && (tx_on || tx_busy);

	// Set wins over the clear by a data write
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tx_empty_r <= TX_EMPTY_RST;
		end else if (tx_take || !serial_unit_on) begin
			tx_empty_r <= 1'b1;
		end else if (data_wr) begin
			tx_empty_r <= 1'b0;
		end
	end

	assign tx_empty_flag = tx_empty_r || !serial_unit_on;
	assign tx_done_flag = !serial_unit_on || (tx_empty_r && !tx_busy && !tx_queued);
	assign tx_irq = serial_unit_on && ((tx_empty_flag && ctrl_two_r[C2_TXE_IE])
		|| (tx_done_flag && ctrl_two_r[C2_TXD_IE]));

	// Receive pin synchroniser
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_sync1_r <= 1'b1;
			rx_sync2_r <= 1'b1;
		end else begin
			rx_sync1_r <= rxd_pin;
			rx_sync2_r <= rx_sync1_r;
		end
	end

	// The echo bypasses the pin synchroniser, so it is the raw transmit line
	assign rx_in = internal_echo_sel ? txd_line : rx_sync2_r;
	assign rx_en = serial_unit_on && rx_on;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_state_r <= RX_IDLE;
			rx_cnt_r <= 13'h0000;
			rx_bits_r <= 4'h0;
			rx_sh_r <= 10'h000;
		end else if (!rx_en) begin
			rx_state_r <= RX_IDLE;
			rx_cnt_r <= 13'h0000;
		end else begin
			unique case (rx_state_r)
				RX_IDLE: begin
					if (!rx_in) begin
						rx_state_r <= RX_START;
						rx_cnt_r <= period >> 1;
					end else if (rx_cnt_r == 13'h0000) begin
						rx_cnt_r <= period - 13'h0001;
					end else begin
						rx_cnt_r <= rx_cnt_r - 13'h0001;
					end
				end
				RX_START: begin
					if (rx_cnt_r != 13'h0000) begin
						rx_cnt_r <= rx_cnt_r - 13'h0001;
					end else if (rx_in) begin
						rx_state_r <= RX_IDLE;
					end else begin
						rx_state_r <= RX_DATA;
						rx_cnt_r <= period - 13'h0001;
						rx_bits_r <= frame_len - 4'h1;
					end
				end
				RX_DATA: begin
					if (rx_cnt_r != 13'h0000) begin
						rx_cnt_r <= rx_cnt_r - 13'h0001;
					end else begin
						rx_sh_r <= {rx_in, rx_sh_r[9:1]};
						rx_bits_r <= rx_bits_r - 4'h1;
						rx_cnt_r <= period - 13'h0001;
						if (rx_bits_r == 4'h1) begin
							rx_state_r <= RX_IDLE;
						end
					end
				end
			endcase
		end
	end

	assign rx_sample = rx_en && rx_state_r == RX_DATA && rx_cnt_r == 13'h0000;
	assign rx_done = rx_sample && rx_bits_r == 4'h1;
	assign rx_full_frame = {rx_in, rx_sh_r[9:1]};
	assign rx_char = char_length_sel ? rx_full_frame[7:0] : rx_full_frame[8:1];
	assign rx_msb = rx_full_frame[8];
	assign rx_par_fail = (char_length_sel ? ^rx_full_frame[8:0] : ^rx_full_frame[8:1])
		!= parity_odd_sel;
	assign rx_accept = rx_done && (!rx_standby || (rx_rouse_sel && rx_msb));

	// Stop bit is only counted when counting starts after the start bit
	assign quiet_inc = rx_en && rx_in && ((rx_state_r == RX_IDLE && rx_cnt_r == 13'h0000)
		|| (rx_sample && !quiet_count_start_sel));
	assign quiet_hit = quiet_inc && quiet_cnt_r == frame_len - 4'h1;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			quiet_cnt_r <= 4'h0;
		end else if (!rx_en || (rx_state_r != RX_IDLE && !quiet_count_start_sel && !rx_in)
			|| rx_state_r == RX_START || (rx_sample && quiet_count_start_sel)) begin
			quiet_cnt_r <= 4'h0;
		end else if (quiet_inc && quiet_cnt_r < frame_len) begin
			quiet_cnt_r <= quiet_cnt_r + 4'h1;
		end
	end

	assign wake = rx_standby && ((rx_rouse_sel && rx_done && rx_msb)
		|| (!rx_rouse_sel && quiet_hit));

	// Idle flag needs a fresh character before it can fire again
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			quiet_armed_r <= 1'b0;
		end else if (rx_accept) begin
			quiet_armed_r <= 1'b1;
		end else if (quiet_hit || data_rd) begin
			quiet_armed_r <= 1'b0;
		end
	end

	// Receiver flags: a set beats a data read clear; disabling leaves them
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_full_r <= 1'b0;
			quiet_r <= 1'b0;
			par_bad_r <= 1'b0;
		end else begin
			if (rx_accept) begin
				rx_full_r <= 1'b1;
			end else if (data_rd) begin
				rx_full_r <= 1'b0;
			end
			if (quiet_hit && quiet_armed_r && !rx_standby) begin
				quiet_r <= 1'b1;
			end else if (data_rd) begin
				quiet_r <= 1'b0;
			end
			if (rx_accept && parity_on && rx_par_fail) begin
				par_bad_r <= 1'b1;
			end else if (data_rd) begin
				par_bad_r <= 1'b0;
			end
		end
	end

	assign rx_irq = !rx_standby && ((rx_full_r && ctrl_two_r[C2_RXF_IE])
		|| (quiet_r && ctrl_two_r[C2_Q_IE]));

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (rd) begin
			unique case (addr)
				ADDR_CTRL_ONE: rdata <= ctrl_one_r;
				ADDR_CTRL_TWO: rdata <= ctrl_two_r;
				ADDR_CTRL_THREE: begin
					rdata <= 8'h00;
					rdata[C3_RX9] <= rx_ninth_r;
					rdata[C3_TX9] <= tx_ninth_r;
				end
				ADDR_STATUS: begin
					rdata <= 8'h00;
					rdata[ST_TXE] <= tx_empty_flag;
					rdata[ST_TXD] <= tx_done_flag;
					rdata[ST_RXF] <= rx_full_r;
					rdata[ST_QUIET] <= quiet_r;
					rdata[ST_PAR] <= par_bad_r;
				end
				ADDR_DATA: rdata <= rx_data_r;
				ADDR_BAUD: rdata <= baud_r;
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// A start bit on the transmit line must reach the receiver, whatever the pin shows
	property p_echo;
		@(posedge core_clk) disable iff (!rstn)
		internal_echo_sel && rx_en && rx_state_r == RX_IDLE && !txd_line
		|=> rx_state_r == RX_START;
	endproperty
	a_echo: assert property (p_echo) else $error("echo path not taken");

	property p_unit_off;
		@(posedge core_clk) disable iff (!rstn)
		!serial_unit_on |=> tx_empty_r;
	endproperty
	a_unit_off: assert property (p_unit_off) else $error("unit off flags wrong");

	property p_off_mask;
		@(posedge core_clk) disable iff (!rstn)
		!serial_unit_on |-> tx_empty_flag && tx_done_flag && !tx_irq;
	endproperty
	a_off_mask: assert property (p_off_mask) else $error("tx request while off");

	property p_frame_len;
		@(posedge core_clk) disable iff (!rstn)
		rx_en && rx_state_r == RX_START && rx_cnt_r == 13'h0000 && !rx_in
		|=> rx_bits_r == (char_length_sel ? 4'ha : 4'h9);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("bad frame length");

	property p_reset;
		@(posedge core_clk) disable iff (!rstn)
		$rose(rstn) |-> ctrl_one_r == 8'h00 && ctrl_two_r == 8'h00;
	endproperty
	a_reset: assert property (p_reset) else $error("control not cleared");

	property p_write;
		@(posedge core_clk) disable iff (!rstn)
		wr && addr == ADDR_CTRL_ONE |=> ctrl_one_r == ($past(wdata) & 8'hdf);
	endproperty
	a_write: assert property (p_write) else $error("write not applied");

	property p_rx_req;
		@(posedge core_clk) disable iff (!rstn)
		rx_accept && !rx_standby && ctrl_two_r[C2_RXF_IE] && !wr |=> rx_irq;
	endproperty
	a_rx_req: assert property (p_rx_req) else $error("missing rx request");

	property p_wake;
		@(posedge core_clk) disable iff (!rstn)
		rx_standby && rx_rouse_sel && rx_done && rx_msb |=> !rx_standby;
	endproperty
	a_wake: assert property (p_wake) else $error("standby not cleared");

	property p_take;
		@(posedge core_clk) disable iff (!rstn)
		tx_take |=> tx_empty_r && tx_busy;
	endproperty
	a_take: assert property (p_take) else $error("empty flag not set");

	property p_parity;
		@(posedge core_clk) disable iff (!rstn)
		rx_accept && parity_on && rx_par_fail |=> par_bad_r;
	endproperty
	a_parity: assert property (p_parity) else $error("parity error missed");

	property p_done;
		@(posedge core_clk) disable iff (!rstn)
		serial_unit_on && (tx_busy || tx_queued) |-> !tx_done_flag;
	endproperty
	a_done: assert property (p_done) else $error("done while sending");

	c_rx_char: cover property (@(posedge core_clk) disable iff (!rstn) rx_accept);
	c_break: cover property (@(posedge core_clk) disable iff (!rstn) break_send && tx_busy);
	c_quiet: cover property (@(posedge core_clk) disable iff (!rstn) $rose(quiet_r));
	c_wake: cover property (@(posedge core_clk) disable iff (!rstn) wake);
endmodule

// ===== design/sci_tx_engine.sv
// Transmit shifter for preamble, break and data frames
module sci_tx_engine
	import sci_ctrl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic bit_tick,
	input wire logic unit_on,
	input wire logic tx_on,
	input wire logic break_send,
	input wire logic nine_bits,
	input wire logic parity_on,
	input wire logic parity_odd,
	input wire logic data_ready,
	input wire logic [7:0] data,
	input wire logic ninth,
	output logic txd,
	output logic take,
	output logic busy,
	output logic queued
);
	logic [10:0] sh_r;
	logic [3:0] left_r;
	logic pend_idle_r;
	logic owe_one_r;
	logic on_seen_r;
	logic [3:0] frame_len;
	logic launch;
	logic par8;
	logic par9;
	logic [10:0] data_frame;

	assign frame_len = nine_bits ? FRAME_LONG : FRAME_SHORT;
	// A new frame is chosen as the last bit ends, so frames run back to back
	assign launch = bit_tick && left_r <= 4'h1;
	assign par9 = ^data ^ parity_odd;
	assign par8 = ^data[6:0] ^ parity_odd;
	assign txd = sh_r[0];
	assign busy = left_r != 4'h0;
	assign queued = pend_idle_r | (tx_on & break_send);
	assign take = launch && tx_on && !break_send && !owe_one_r && !pend_idle_r && data_ready;

	always_comb begin
		if (nine_bits) begin
			data_frame = {1'b1, parity_on ? par9 : ninth, data, 1'b0};
		end else begin
			data_frame = {2'b11, parity_on ? par8 : data[7], data[6:0], 1'b0};
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			on_seen_r <= 1'b0;
		end else begin
			on_seen_r <= tx_on;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pend_idle_r <= 1'b0;
		end else if (!unit_on) begin
			pend_idle_r <= 1'b0;
		end else if (tx_on && !on_seen_r) begin
			pend_idle_r <= 1'b1;
		end else if (launch && tx_on && (break_send || !owe_one_r)) begin
			pend_idle_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sh_r <= '1;
			left_r <= 4'h0;
			owe_one_r <= 1'b0;
		end else if (!unit_on) begin
			sh_r <= '1;
			left_r <= 4'h0;
			owe_one_r <= 1'b0;
		end else if (launch) begin
			if (!tx_on) begin
				sh_r <= '1;
				left_r <= 4'h0;
			end else if (break_send) begin
				sh_r <= '0;
				left_r <= frame_len;
				owe_one_r <= 1'b1;
			end else if (owe_one_r) begin
				sh_r <= '1;
				left_r <= 4'h1;
				owe_one_r <= 1'b0;
			end else if (pend_idle_r) begin
				sh_r <= '1;
				left_r <= frame_len;
			end else if (data_ready) begin
				sh_r <= data_frame;
				left_r <= frame_len;
			end else begin
				sh_r <= '1;
				left_r <= 4'h0;
			end
		end else if (bit_tick && left_r > 4'h1) begin
			sh_r <= {1'b1, sh_r[10:1]};
			left_r <= left_r - 4'h1;
		end
	end
endmodule

// ===== shared/sci_ctrl_pkg.sv
// Shared constants for the serial control-register block
// Functional notes
// - Echo mode feeds transmitter output into receiver
// - Unit off forces empty/done flags, masks tx
// - Length select picks eight or nine bit characters
// - One start, one stop; ten or eleven bits
// - Wake by address mark or idle line
// - Idle counting starts after start or stop
// - Parity bit occupies character MSB, checked on receive
// - Parity select chooses odd or even parity
// - Reset clears both first control registers
// - Request raised when flag and enable both set
// - Transmitter enable sends all-ones preamble first
// - Disabling transmitter finishes current character first
// - Re-enable mid-frame queues one idle character
// - Receiver disable keeps receiver flags intact
// - Standby masks receive requests, hardware wakes it
// - Break toggle sends break then one mark
// - Held break sends breaks back to back
// - Break before preamble replaces the preamble
// - Received ninth bit read-only, bit 8/7
// - Transmit ninth bit loads with data
// - Transmit ninth bit untouched by reset
// - Empty flag sets on hand-off, reset sets
// - Done flag tracks empty and idle transmitter
package sci_ctrl_pkg;
	localparam logic [2:0] ADDR_CTRL_ONE = 3'h0;
	localparam logic [2:0] ADDR_CTRL_TWO = 3'h1;
	localparam logic [2:0] ADDR_CTRL_THREE = 3'h2;
	localparam logic [2:0] ADDR_STATUS = 3'h3;
	localparam logic [2:0] ADDR_DATA = 3'h4;
	localparam logic [2:0] ADDR_BAUD = 3'h5;
	localparam int C1_ECHO = 7;
	localparam int C1_UNIT = 6;
	localparam int C1_LEN = 4;
	localparam int C1_ROUSE = 3;
	localparam int C1_QSTART = 2;
	localparam int C1_PAR = 1;
	localparam int C1_ODD = 0;
	localparam int C2_TXE_IE = 7;
	localparam int C2_TXD_IE = 6;
	localparam int C2_RXF_IE = 5;
	localparam int C2_Q_IE = 4;
	localparam int C2_TX_ON = 3;
	localparam int C2_RX_ON = 2;
	localparam int C2_STBY = 1;
	localparam int C2_BRK = 0;
	localparam int C3_RX9 = 7;
	localparam int C3_TX9 = 6;
	localparam int ST_TXE = 7;
	localparam int ST_TXD = 6;
	localparam int ST_RXF = 5;
	localparam int ST_QUIET = 4;
	localparam int ST_PAR = 0;
	localparam logic [7:0] CTRL_ONE_MASK = 8'hdf;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic TX_EMPTY_RST = 1'b1;
	localparam logic [3:0] FRAME_SHORT = 4'ha;
	localparam logic [3:0] FRAME_LONG = 4'hb;
	localparam int OVERSAMPLE_SHIFT = 4;
endpackage
